// *** dv/cds_far_model.sv ***
/*
 Board return path from channel 0 driver to the zero-delay input.
 Assumes the trace floats when the driver is off.
*/
`timescale 1ns/1ps
`default_nettype none

module cds_far_model (
   // Clock
   input wire logic core_clk,
   // Channel 0 driver
   input wire logic drvOut,
   input wire logic drvOe,
   // Return path
   output logic fbIn
);
   logic lastLevel = 1'b0;

   always @(posedge core_clk)
      if (drvOe)
         lastLevel <= drvOut;

   // Floating trace shows the inverse of the last level
   assign fbIn = drvOe ? drvOut : ~lastLevel;
endmodule

`default_nettype wire

// *** dv/cds_top_props.sv ***
/*
 Port checker for cds_top.
 Assumes a bind from the bench top file.
*/
`timescale 1ns/1ps
`default_nettype none

module cds_top_props (
   // Clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // Register bus
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic [1:0] bresp,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic [31:0] rdata,
   // Pins and channels
   input wire logic syncPinN,
   input wire logic coreSynthLoopLocked,
   input wire logic [13:0] chanOut,
   input wire logic [13:0] chanOe,
   input wire logic [55:0] chanMode,
   input wire logic [13:0] chanPowerDown
);
   logic lockSeen;
   logic [13:0] triMask;

   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);

   // ========================================
   // Helpers
   always @(posedge core_clk)
      if (!resetn)
         lockSeen <= 1'b0;
      else if (coreSynthLoopLocked)
         lockSeen <= 1'b1;

   always_comb
      for (int i = 0; i < 14; i++)
         triMask[i] = (chanMode[4*i +: 4] == 4'hF);

   // ========================================
   // Properties
   property p_heldUntilLock;
      !lockSeen |-> chanOe == 14'h0000;
   endproperty
   a_heldUntilLock: assert property (p_heldUntilLock)
      else $error("output enabled before first lock");

   property p_offIsZero;
      (chanOut & ~chanOe) == 14'h0000;
   endproperty
   a_offIsZero: assert property (p_offIsZero)
      else $error("disabled output not low");

   property p_powerDown;
      (chanOe & chanPowerDown & $past(chanPowerDown) & $past(chanPowerDown, 2)) == 14'h0000;
   endproperty
   a_powerDown: assert property (p_powerDown)
      else $error("powered down channel drives");

   property p_tristate;
      (chanOe & triMask & $past(triMask) & $past(triMask, 2)) == 14'h0000;
   endproperty
   a_tristate: assert property (p_tristate)
      else $error("tristate channel drives");

   property p_pinHold;
      !syncPinN [*4] |-> (chanOe & ~$past(chanOe)) == 14'h0000;
   endproperty
   a_pinHold: assert property (p_pinHold)
      else $error("channel enabled while sync pin low");

   property p_bHold;
      bvalid && !bready |=> bvalid && $stable(bresp);
   endproperty
   a_bHold: assert property (p_bHold)
      else $error("write response dropped early");

   property p_rHold;
      rvalid && !rready |=> rvalid && $stable(rdata);
   endproperty
   a_rHold: assert property (p_rHold)
      else $error("read data dropped early");

   property p_wAnswer;
      awvalid && awready && wvalid && wready |-> ##2 bvalid;
   endproperty
   a_wAnswer: assert property (p_wAnswer)
      else $error("write response late");

   property p_rAnswer;
      arvalid && arready |=> rvalid;
   endproperty
   a_rAnswer: assert property (p_rAnswer)
      else $error("read data late");
endmodule

`default_nettype wire

// *** dv/cds_top_tb_top.sv ***
/*
 Self-checking bench for cds_top.
 Assumes cds_defs.vh on the include path.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cds_defs.vh"

module cds_top_tb_top;
   logic core_clk = 1'b0;
   logic resetn = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic [31:0] wdata = 32'h0000_0000;
   logic syncPinN = 1'b1, coreSynthLoopLocked = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, loopFeedback, zeroDelayFeedbackInput;
   logic [1:0] bresp, rresp, resp;
   logic [31:0] rdata, rd;
   logic [13:0] chanOut, chanOe, chanPowerDown, chanLowPower;
   logic [55:0] chanMode;
   logic s5 [0:39];
   int errors = 0, numChecks = 0, cycles = 0, t5, t6, k, c;
   logic [11:0] rowA [0:9] = '{12'h640, 12'h644, 12'h06C, 12'h680, 12'h68C, 12'h690,
      12'h658, 12'h664, 12'h670, 12'hFFC};
   logic [31:0] rowD [0:9] = '{32'hABCD_0012, 32'h0000_0003, 32'h0000_0020, 32'h0000_0002,
      32'h0000_0002, 32'h0000_000C, 32'h0000_0080, 32'h0000_0040, 32'h0000_000F, 32'h0000_0055};
   logic [31:0] rowE [0:9] = '{32'h0000_0012, 32'h0000_0003, 32'h0000_0020, 32'h0000_0002,
      32'h0000_0002, 32'h0000_000C, 32'h0000_0080, 32'h0000_0040, 32'h0000_000F, 32'h0000_0000};
   logic [1:0] rowR [0:9] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0,
      `CDS_RESP_SLVERR};

   cds_top dut_u (.core_clk, .resetn, .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid,
      .wready, .wdata, .wstrb(4'hF), .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
      .arprot(3'h0), .rvalid, .rready, .rdata, .rresp, .syncPinN, .coreSynthLoopLocked,
      .zeroDelayFeedbackInput, .chanOut, .chanOe, .chanMode, .chanPowerDown,
      .chanLowPower, .loopFeedback);
   cds_far_model far_u (.core_clk, .drvOut(chanOut[0]), .drvOe(chanOe[0]),
      .fbIn(zeroDelayFeedbackInput));

   initial forever #2 core_clk = ~core_clk;

   // ========================================
   // Tasks
   task automatic check(input logic [31:0] s, input logic [31:0] e);
      numChecks++;
      if (s !== e)
      begin
         errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask

   task automatic summarize();
      $display("checks %0d errors %0d", numChecks, errors);
      if (errors == 0 && numChecks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic wrReg(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
      logic ad, dd;
      @(posedge core_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      ad = 1'b0;
      dd = 1'b0;
      while (!(ad && dd))
      begin
         @(posedge core_clk);
         if (awready && !ad)
         begin
            ad = 1'b1;
            awvalid <= 1'b0;
         end
         if (wready && !dd)
         begin
            dd = 1'b1;
            wvalid <= 1'b0;
         end
      end
      while (!bvalid)
         @(posedge core_clk);
      r = bresp;
      bready <= 1'b0;
   endtask

   task automatic rdReg(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge core_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge core_clk); while (!arready);
      arvalid <= 1'b0;
      while (!rvalid)
         @(posedge core_clk);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask

   task automatic waitOe(input int n, input logic v);
      for (int i = 0; i < 60 && chanOe[n] !== v; i++)
         @(posedge core_clk);
      check(chanOe[n], v);
   endtask

   // Ch5 and ch6 share divide 3; ch6 carries ph steps of phase
   task automatic measure(input int ph);
      t5 = -1;
      t6 = -1;
      for (int i = 0; i < 40; i++)
      begin
         @(posedge core_clk);
         s5[i] = chanOut[5];
         if (t5 < 0 && chanOut[5])
            t5 = i;
         if (t6 < 0 && chanOut[6])
            t6 = i;
      end
      check(t6 - t5, ph);
      check(s5[t5 + 2], 1'b1);
      check(s5[t5 + 3], 1'b0);
   endtask

   task automatic countFb(output int n);
      logic p;
      n = 0;
      p = loopFeedback;
      for (int i = 0; i < 24; i++)
      begin
         @(posedge core_clk);
         if (loopFeedback !== p)
            n++;
         p = loopFeedback;
      end
   endtask

   // ========================================
   // Timeout
   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         errors++;
         summarize();
      end
   end

   // ========================================
   // Sequence
   initial
   begin
      repeat (5) @(posedge core_clk);
      resetn <= 1'b1;
      repeat (2) @(posedge core_clk);
      rdReg(12'h640, rd, resp);
      check(rd, `CDS_CFG_RESET);
      for (k = 0; k < 10; k++)
      begin
         wrReg(rowA[k], rowD[k], resp);
         check(resp, rowR[k]);
         rdReg(rowA[k], rd, resp);
         check(rd, rowE[k]);
         check(resp, rowR[k]);
      end
      check(chanOe, 14'h0000);
      $display("test registers done");
      coreSynthLoopLocked <= 1'b1;
      measure(3);
      check(chanOe[13], 1'b1);
      check(chanMode[3:0], 4'h2);
      check(chanMode[19:16], `CDS_MODE_TRISTATE);
      check(chanOe[4], 1'b0);
      check(chanPowerDown[3], 1'b1);
      check(chanOe[3], 1'b0);
      coreSynthLoopLocked <= 1'b0;
      c = 0;
      for (k = 0; k < 40; k++)
      begin
         @(posedge core_clk);
         if (k == 20)
            coreSynthLoopLocked <= 1'b1;
         if (chanOe[13] !== 1'b1)
            c++;
      end
      check(c, 0);
      $display("test autoSync done");
      check(chanLowPower[2], 1'b1);
      wrReg(12'h658, 32'h0000_0020, resp);
      wrReg(12'h8C8, 32'h0000_0001, resp);
      repeat (8) @(posedge core_clk);
      check(chanOe[13], 1'b1);
      wrReg(12'h8C8, 32'h0000_0000, resp);
      waitOe(13, 1'b0);
      check(chanOe[2], 1'b1);
      check(chanOe[12], 1'b0);
      waitOe(13, 1'b1);
      $display("test softSync done");
      wrReg(12'h690, 32'h0000_0014, resp);
      syncPinN <= 1'b0;
      waitOe(13, 1'b0);
      repeat (4) @(posedge core_clk);
      check(chanOe[13], 1'b0);
      check(chanOe[2], 1'b1);
      syncPinN <= 1'b1;
      measure(5);
      $display("test pinSync done");
      wrReg(12'h640, 32'h0000_001F, resp);
      countFb(c);
      check(c != 0, 1'b1);
      wrReg(12'h06C, 32'h0000_0000, resp);
      repeat (6) @(posedge core_clk);
      countFb(c);
      check(c, 0);
      wrReg(12'h640, 32'h0000_0002, resp);
      repeat (6) @(posedge core_clk);
      countFb(c);
      check(c != 0, 1'b1);
      $display("test zeroDelay done");
      resetn <= 1'b0;
      repeat (5) @(posedge core_clk);
      resetn <= 1'b1;
      repeat (2) @(posedge core_clk);
      check(chanOe, 14'h0000);
      waitOe(13, 1'b1);
      rdReg(12'h640, rd, resp);
      check(rd, `CDS_CFG_RESET);
      $display("test midReset done");
      summarize();
   end
endmodule

bind cds_top cds_top_props chk_u (.core_clk, .resetn, .awvalid, .awready, .wvalid, .wready,
   .bvalid, .bready, .bresp, .arvalid, .arready, .rvalid, .rready, .rdata, .syncPinN,
   .coreSynthLoopLocked, .chanOut, .chanOe, .chanMode, .chanPowerDown);

`default_nettype wire

// *** src/cds_channel_div.v ***
/*
 One distribution channel divider with phase preset and 50% duty.
 Assumes core_clk ticks once per half period of the divider input clock.
*/
`timescale 1ns/1ps
`default_nettype none

module cds_channel_div (
   // Clock and reset
   input wire core_clk,
   input wire resetn,
   // Controls
   input wire syncHold,
   input wire ignoreSync,
   input wire powerDown,
   input wire invert,
   input wire [9:0] divSetting,
   input wire [5:0] phaseSteps,
   // Result
   output reg divOut,
   output reg active
);

   reg [10:0] halfCnt;
   reg [5:0] phaseWait;
   wire [10:0] ratio = {1'b0, divSetting} + 11'h001;
   wire [11:0] lastCnt = {ratio, 1'b0} - 12'h001;

   always @(posedge core_clk)
   begin
      if (!resetn)
      begin
         halfCnt <= 11'h000;
         phaseWait <= 6'h00;
         divOut <= 1'b0;
         active <= 1'b0;
      end
      else if (powerDown)
      begin
         // Whole channel off
         halfCnt <= 11'h000;
         phaseWait <= 6'h00;
         divOut <= 1'b0;
         active <= 1'b0;
      end
      else if (syncHold && !ignoreSync)
      begin
         // Held disabled, preset for first period
         halfCnt <= 11'h000;
         phaseWait <= phaseSteps;
         divOut <= 1'b0;
         active <= 1'b0;
      end
      else if (phaseWait != 6'h00)
      begin
         // Offset in half periods before first edge
         phaseWait <= phaseWait - 6'h01;
         divOut <= invert;
         active <= 1'b1;
      end
      else
      begin
         if ({1'b0, halfCnt} >= lastCnt)
            halfCnt <= 11'h000;
         else
            halfCnt <= halfCnt + 11'h001;
         divOut <= (halfCnt < ratio) ^ invert;
         active <= 1'b1;
      end
   end

endmodule

`default_nettype wire

// *** src/cds_defs.vh ***
/*
 Constants for the clock distribution sync block: register indices,
 field positions, reset values and hold counts.
 Assumes inclusion by bare name from the design files.
*/
`ifndef CDS_DEFS_VH
`define CDS_DEFS_VH

// ========================================
// Sizes
`define CDS_NUM_CH 14
`define CDS_ADDR_W 12

// ========================================
// Register indices (byte address = 4 * index)
`define CDS_IDX_ZD 10'h01B
`define CDS_IDX_CH0 10'h190
`define CDS_IDX_STATUS 10'h22C
`define CDS_IDX_SYNC 10'h232

// ========================================
// Fields
`define CDS_ZD_BIT 5
`define CDS_SYNC_BIT 0
`define CDS_F_MODE 3:0
`define CDS_F_INV 4
`define CDS_F_IGN 5
`define CDS_F_PD 6
`define CDS_F_LP 7
`define CDS_F_DIVLO 15:8
`define CDS_F_DIVHI 17:16
`define CDS_F_PHASE 23:18
`define CDS_MODE_TRISTATE 4'hF
`define CDS_CFG_RESET 24'h00_0000

// ========================================
// Timing and bus answers
`define CDS_SW_HOLD 4'h4
`define CDS_RESP_OKAY 2'b00
`define CDS_RESP_SLVERR 2'b10

`endif

// *** src/cds_sync2.v ***
/*
 Two-flop synchroniser for a group of asynchronous levels.
 Assumes the inputs may change at any time relative to core_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module cds_sync2 #(
   parameter W = 1
) (
   // Clock and reset
   input wire core_clk,
   input wire resetn,
   // Levels
   input wire [W-1:0] asyncIn,
   output reg [W-1:0] syncOut
);

   reg [W-1:0] stage1;

   always @(posedge core_clk)
   begin
      if (!resetn)
      begin
         stage1 <= {W{1'b0}};
         syncOut <= {W{1'b0}};
      end
      else
      begin
         stage1 <= asyncIn;
         syncOut <= stage1;
      end
   end

endmodule

`default_nettype wire

// *** src/cds_top.v ***
/*
 Clock distribution sync block: fourteen channel dividers, sync control,
 zero-delay feedback mux and an AXI4-Lite register slave.
 Assumes core_clk is the divider input clock at twice its rate, and that
 the sync pin, lock and zero-delay inputs are asynchronous.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cds_defs.vh"

module cds_top (
   // Clock and reset
   input wire core_clk,
   input wire resetn,
   // AXI4-Lite write address
   input wire awvalid,
   output reg awready,
   input wire [`CDS_ADDR_W-1:0] awaddr,
   input wire [2:0] awprot,
   // AXI4-Lite write data
   input wire wvalid,
   output reg wready,
   input wire [31:0] wdata,
   input wire [3:0] wstrb,
   // AXI4-Lite write response
   output reg bvalid,
   input wire bready,
   output reg [1:0] bresp,
   // AXI4-Lite read address
   input wire arvalid,
   output reg arready,
   input wire [`CDS_ADDR_W-1:0] araddr,
   input wire [2:0] arprot,
   // AXI4-Lite read data
   output reg rvalid,
   input wire rready,
   output reg [31:0] rdata,
   output reg [1:0] rresp,
   // Pins and loop status
   input wire syncPinN,
   input wire coreSynthLoopLocked,
   input wire zeroDelayFeedbackInput,
   // Channel drivers
   output reg [13:0] chanOut,
   output reg [13:0] chanOe,
   output reg [55:0] chanMode,
   output reg [13:0] chanPowerDown,
   output reg [13:0] chanLowPower,
   // Input loop feedback
   output reg loopFeedback
);

   // ========================================
   // Address decode
   // {hit, channel, byte} for a channel register index
   function [6:0] chDecode;
      input [9:0] idx;
      integer c;
      reg [9:0] off;
      reg [9:0] rem;
      begin
         chDecode = 7'h00;
         off = idx - `CDS_IDX_CH0;
         for (c = 0; c < `CDS_NUM_CH; c = c + 1)
         begin
            rem = off - (c[9:0] * 10'h003);
            if (off >= c[9:0] * 10'h003 && rem < 10'h003)
               chDecode = {1'b1, c[3:0], rem[1:0]};
         end
      end
   endfunction

   // ========================================
   // Storage
   reg [23:0] chCfg [0:13];
   reg zdInternal;
   reg swSync;
   reg [3:0] swHoldCnt;
   reg autoDone;
   reg syncActive;
   reg awHeld;
   reg wHeld;
   reg [9:0] awIdx;
   reg [31:0] wDataHeld;
   reg [3:0] wStrbHeld;
   reg next_awHeld;
   reg next_wHeld;
   reg next_bvalid;
   reg next_rvalid;
   reg [31:0] readWord;
   reg readHit;
   reg [6:0] rdDec;
   integer k;

   wire [2:0] syncedIn;
   wire pinLow = ~syncedIn[0];
   wire locked = syncedIn[1];
   wire zdIn = syncedIn[2];
   wire [6:0] wrDec = chDecode(awIdx);
   wire doWrite = awHeld & wHeld & ~bvalid;
   wire wrLane = doWrite & wStrbHeld[0];
   wire wrSync = wrLane && awIdx == `CDS_IDX_SYNC;
   wire swFall = wrSync & swSync & ~wDataHeld[`CDS_SYNC_BIT];
   wire wrHit = wrDec[6] || awIdx == `CDS_IDX_ZD || awIdx == `CDS_IDX_SYNC ||
                awIdx == `CDS_IDX_STATUS;

   // ========================================
   // Input synchronisers
   cds_sync2 #(
      .W(3)
   ) u_sync (
      .core_clk(core_clk),
      .resetn(resetn),
      .asyncIn({zeroDelayFeedbackInput, coreSynthLoopLocked, syncPinN}),
      .syncOut(syncedIn)
   );

   // ========================================
   // AXI4-Lite handshake state
   always @*
   begin
      next_awHeld = awHeld;
      next_wHeld = wHeld;
      next_bvalid = bvalid;
      next_rvalid = rvalid;
      if (awvalid && awready)
         next_awHeld = 1'b1;
      if (wvalid && wready)
         next_wHeld = 1'b1;
      if (doWrite)
      begin
         next_awHeld = 1'b0;
         next_wHeld = 1'b0;
         next_bvalid = 1'b1;
      end
      else if (bvalid && bready)
         next_bvalid = 1'b0;
      if (arvalid && arready)
         next_rvalid = 1'b1;
      else if (rvalid && rready)
         next_rvalid = 1'b0;
   end

   always @(posedge core_clk)
   begin
      if (!resetn)
      begin
         awready <= 1'b0;
         wready <= 1'b0;
         bvalid <= 1'b0;
         bresp <= `CDS_RESP_OKAY;
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= `CDS_RESP_OKAY;
         awHeld <= 1'b0;
         wHeld <= 1'b0;
         awIdx <= 10'h000;
         wDataHeld <= 32'h0000_0000;
         wStrbHeld <= 4'h0;
      end
      else
      begin
         awHeld <= next_awHeld;
         wHeld <= next_wHeld;
         bvalid <= next_bvalid;
         rvalid <= next_rvalid;
         awready <= ~next_awHeld & ~next_bvalid;
         wready <= ~next_wHeld & ~next_bvalid;
         arready <= ~next_rvalid;
         if (awvalid && awready)
            awIdx <= awaddr[`CDS_ADDR_W-1:2];
         if (wvalid && wready)
         begin
            wDataHeld <= wdata;
            wStrbHeld <= wstrb;
         end
         if (doWrite)
            bresp <= wrHit ? `CDS_RESP_OKAY : `CDS_RESP_SLVERR;
         if (arvalid && arready)
         begin
            rdata <= readWord;
            rresp <= readHit ? `CDS_RESP_OKAY : `CDS_RESP_SLVERR;
         end
      end
   end

   // ========================================
   // Read mux
   always @*
   begin
      readWord = 32'h0000_0000;
      readHit = 1'b1;
      rdDec = chDecode(araddr[`CDS_ADDR_W-1:2]);
      if (rdDec[6])
      begin
         case (rdDec[1:0])
            2'b00: readWord[7:0] = chCfg[rdDec[5:2]][7:0];
            2'b01: readWord[7:0] = chCfg[rdDec[5:2]][15:8];
            default: readWord[7:0] = chCfg[rdDec[5:2]][23:16];
         endcase
      end
      else
      begin
         case (araddr[`CDS_ADDR_W-1:2])
            `CDS_IDX_ZD: readWord[`CDS_ZD_BIT] = zdInternal;
            `CDS_IDX_SYNC: readWord[`CDS_SYNC_BIT] = swSync;
            `CDS_IDX_STATUS: readWord[2:0] = {locked, autoDone, syncActive};
            default: readHit = 1'b0;
         endcase
      end
   end

   // ========================================
   // Register writes
   always @(posedge core_clk)
   begin
      if (!resetn)
      begin
         zdInternal <= 1'b0;
         swSync <= 1'b0;
         for (k = 0; k < `CDS_NUM_CH; k = k + 1)
            chCfg[k] <= `CDS_CFG_RESET;
      end
      else if (wrLane)
      begin
         if (wrDec[6])
         begin
            // Phase lands here but only takes effect at the next sync
            case (wrDec[1:0])
               2'b00: chCfg[wrDec[5:2]][7:0] <= wDataHeld[7:0];
               2'b01: chCfg[wrDec[5:2]][15:8] <= wDataHeld[7:0];
               default: chCfg[wrDec[5:2]][23:16] <= wDataHeld[7:0];
            endcase
         end
         if (awIdx == `CDS_IDX_ZD)
            zdInternal <= wDataHeld[`CDS_ZD_BIT];
         if (awIdx == `CDS_IDX_SYNC)
            swSync <= wDataHeld[`CDS_SYNC_BIT];
      end
   end

   // ========================================
   // Sync controller
   always @(posedge core_clk)
   begin
      if (!resetn)
      begin
         swHoldCnt <= 4'h0;
         autoDone <= 1'b0;
         syncActive <= 1'b1;
      end
      else
      begin
         if (swFall)
            swHoldCnt <= `CDS_SW_HOLD;
         else if (swHoldCnt != 4'h0)
            swHoldCnt <= swHoldCnt - 4'h1;
         // Only the first lock after reset counts
         if (locked)
            autoDone <= 1'b1;
         // One shared hold releases every divider without ignoreSync or powerDown set on the same edge
         syncActive <= pinLow | swFall | (swHoldCnt > 4'h1) | ~locked & ~autoDone;
      end
   end

   // ========================================
   // Channels
   wire [13:0] divLevel;
   wire [13:0] divActive;
   wire [13:0] tristated;
   wire [13:0] pdBus;
   wire [13:0] lpBus;
   wire [55:0] modeBus;

   genvar i;
   generate
      for (i = 0; i < `CDS_NUM_CH; i = i + 1)
      begin : g_ch
         wire [23:0] cfg = chCfg[i];
         assign modeBus[4*i+3:4*i] = cfg[`CDS_F_MODE];
         assign tristated[i] = cfg[`CDS_F_MODE] == `CDS_MODE_TRISTATE;
         assign pdBus[i] = cfg[`CDS_F_PD];
         assign lpBus[i] = cfg[`CDS_F_LP];
         // Only channel dividers see the hold; core_clk runs on
         cds_channel_div u_div (
            .core_clk(core_clk),
            .resetn(resetn),
            .syncHold(syncActive),
            .ignoreSync(cfg[`CDS_F_IGN]),
            .powerDown(cfg[`CDS_F_PD]),
            .invert(cfg[`CDS_F_INV]),
            .divSetting({cfg[`CDS_F_DIVHI], cfg[`CDS_F_DIVLO]}),
            .phaseSteps(cfg[`CDS_F_PHASE]),
            .divOut(divLevel[i]),
            .active(divActive[i])
         );
      end
   endgenerate

   // ========================================
   // Driver and feedback outputs
   always @(posedge core_clk)
   begin
      if (!resetn)
      begin
         chanOut <= 14'h0000;
         chanOe <= 14'h0000;
         chanMode <= 56'h00_0000_0000_0000;
         chanPowerDown <= 14'h0000;
         chanLowPower <= 14'h0000;
         loopFeedback <= 1'b0;
      end
      else
      begin
         chanOut <= divLevel & ~tristated;
         // Tristate only gates the driver; the divider keeps counting
         chanOe <= divActive & ~tristated;
         chanMode <= modeBus;
         chanPowerDown <= pdBus;
         chanLowPower <= lpBus;
         if (zdInternal)
            loopFeedback <= divLevel[0];
         else
            loopFeedback <= zdIn;
      end
   end

endmodule

`default_nettype wire
